//--- cbs_slot_ctrl.sv
// Message slot control word with an AXI4-Lite register slave.
// Assumes the protocol engine drives one-cycle event pulses on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module cbs_slot_ctrl (
  input wire logic ref_clk, // Module clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic eng_copy_start, // Engine starts copying a frame in
  input wire logic eng_copy_done, // Engine finished the copy
  input wire logic [3:0] eng_rx_len, // Received length code, with copy_done
  input wire logic [31:0] eng_rx_data, // Received payload word, with copy_done
  input wire logic eng_tx_queue, // Scheduler queues this slot
  input wire logic eng_tx_done, // Frame of this slot was sent
  input wire logic eng_tx_abort, // Scheduler drops this slot
  output logic [3:0] slot_condition, // Condition code for the engine
  output logic [3:0] slot_rank, // Send rank code for the scheduler
  output logic [3:0] slot_byte_count, // Bytes to send, clamped
  output logic [31:0] slot_data // Payload word for the engine
);
  // Stored control fields
  logic [3:0] len_r; // Length code
  logic [3:0] len_nxt; // Next length code
  logic [3:0] rank_r; // Send rank code
  logic [3:0] rank_nxt; // Next rank code
  logic [3:0] cond_r; // Condition code
  logic [3:0] cond_nxt; // Next condition code
  logic [31:0] data_r; // Guarded payload word
  logic [31:0] data_nxt; // Next payload word
  // Write channel state
  logic aw_held_r; // Write address taken
  logic [7:0] aw_addr_r; // Taken write address
  logic w_held_r; // Write data taken
  logic [31:0] w_data_r; // Taken write data
  logic [3:0] w_strb_r; // Taken write strobes
  logic bvalid_r; // Write response pending
  logic [1:0] bresp_r; // Write response code
  // Read channel state
  logic rvalid_r; // Read data pending
  logic [31:0] rdata_r; // Read data
  logic [1:0] rresp_r; // Read response code
  // Engine event decode
  logic [3:0] eng_cond; // Condition after engine event
  logic eng_hit; // Engine changes condition this cycle
  logic [3:0] rx_count; // Clamped received length
  // Write and read decode
  logic wr_fire; // Both halves held, response free
  logic wr_ctrl; // Write hits the control word
  logic wr_data; // Write hits the payload word
  logic wr_map; // Write address is mapped
  logic busy; // Occupied flag now
  logic low_only; // Only the low byte lane is enabled
  logic wr_ok; // Write allowed
  logic host_low; // Host writes rank and condition
  logic host_high; // Host writes length byte
  logic [3:0] host_cond; // Condition the host asks for
  logic [3:0] host_cond_eff; // Condition after busy substitution
  logic [15:0] control_word; // Assembled control word
  logic [31:0] engine_view; // Engine side read back
  logic rd_take; // Read address taken
  logic [31:0] rd_word; // Decoded read data
  logic [1:0] rd_resp; // Decoded read response

  // Engine state changes
  cbs_cond_next u_cond_next (
    .cond(cond_r),
    .copy_start(eng_copy_start),
    .copy_done(eng_copy_done),
    .tx_queue(eng_tx_queue),
    .tx_done(eng_tx_done),
    .tx_abort(eng_tx_abort),
    .cond_nxt(eng_cond),
    .hit(eng_hit)
  );

  // Received length is stored clamped
  cbs_len_clamp u_rx_clamp (
    .len_code(eng_rx_len),
    .byte_count(rx_count)
  );

  // Send length for the engine, clamped
  cbs_len_clamp u_tx_clamp (
    .len_code(len_r),
    .byte_count(slot_byte_count)
  );

  // Assembled word, reserved bits read zero
  assign control_word = {len_r, 4'h0, rank_r, cond_r};
  assign engine_view = {16'h0000, 12'h000, cond_r};
  assign busy = cond_r[cbs_pkg::BUSY_BIT];

  // Write decode
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ctrl = aw_addr_r[7:2] == cbs_pkg::OFS_SLOT_CONTROL[7:2];
  assign wr_data = aw_addr_r[7:2] == cbs_pkg::OFS_SLOT_DATA[7:2];
  assign wr_map = wr_ctrl || wr_data || (aw_addr_r[7:2] == cbs_pkg::OFS_ENGINE_VIEW[7:2]);
  assign low_only = w_strb_r[3:1] == 3'b000;
  // Occupied slot takes only low byte writes of the control word
  assign wr_ok = !busy || (wr_ctrl && low_only);
  assign host_low = wr_fire && wr_ctrl && wr_ok && w_strb_r[0];
  assign host_high = wr_fire && wr_ctrl && wr_ok && w_strb_r[1];
  assign host_cond = w_data_r[cbs_pkg::COND_MSB:0];
  // Idle of the slot's own direction written to a busy slot keeps the busy bit showing
  assign host_cond_eff = (busy && host_cond == cbs_pkg::C_RX_IDLE && !cond_r[3]) ?
                         cbs_pkg::C_RX_IDLE_BUSY :
                         (busy && host_cond == cbs_pkg::C_TX_IDLE && cond_r[3]) ?
                         cbs_pkg::C_TX_IDLE_BUSY : host_cond;

  // Next value of the condition: engine first, host otherwise
  always_comb
  begin
    cond_nxt = cond_r;
    if (eng_hit)
      cond_nxt = eng_cond;
    else if (host_low && host_cond_eff != cbs_pkg::C_TX_RESERVED)
      cond_nxt = host_cond_eff;
  end

  // Next value of length, rank and payload
  always_comb
  begin
    len_nxt = len_r;
    rank_nxt = rank_r;
    data_nxt = data_r;
    if (eng_hit && eng_copy_done)
    begin
      len_nxt = rx_count;
      data_nxt = eng_rx_data;
    end
    else
    begin
      if (host_high)
        len_nxt = w_data_r[cbs_pkg::LEN_MSB:cbs_pkg::LEN_LSB];
      if (wr_fire && wr_data && wr_ok)
        data_nxt = w_data_r;
    end
    if (host_low)
      rank_nxt = w_data_r[cbs_pkg::RANK_MSB:cbs_pkg::RANK_LSB];
  end

  // Control registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      len_r <= cbs_pkg::CONTROL_RESET[cbs_pkg::LEN_MSB:cbs_pkg::LEN_LSB];
      rank_r <= cbs_pkg::CONTROL_RESET[cbs_pkg::RANK_MSB:cbs_pkg::RANK_LSB];
      cond_r <= cbs_pkg::CONTROL_RESET[cbs_pkg::COND_MSB:0];
      data_r <= cbs_pkg::DATA_RESET;
    end
    else
    begin
      len_r <= len_nxt;
      rank_r <= rank_nxt;
      cond_r <= cond_nxt;
      data_r <= data_nxt;
    end
  end

  // Write address and data are taken in either order
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end
    else if (wr_fire)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // Write response; refused writes answer SLVERR so software can tell
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= cbs_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= !wr_map ? cbs_pkg::RESP_DECERR :
                 wr_ok ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Read decode; reads are never refused
  assign rd_take = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign rd_word = (s_axi_araddr[7:2] == cbs_pkg::OFS_SLOT_CONTROL[7:2]) ? {16'h0000, control_word} :
                   (s_axi_araddr[7:2] == cbs_pkg::OFS_SLOT_DATA[7:2]) ? data_r :
                   (s_axi_araddr[7:2] == cbs_pkg::OFS_ENGINE_VIEW[7:2]) ? engine_view :
                   32'h00000000;
  assign rd_resp = ((s_axi_araddr[7:2] == cbs_pkg::OFS_SLOT_CONTROL[7:2]) ||
                    (s_axi_araddr[7:2] == cbs_pkg::OFS_SLOT_DATA[7:2]) ||
                    (s_axi_araddr[7:2] == cbs_pkg::OFS_ENGINE_VIEW[7:2])) ?
                   cbs_pkg::RESP_OKAY : cbs_pkg::RESP_DECERR;

  // Read data register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= cbs_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_resp;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Engine side views come straight from the registers
  assign slot_condition = cond_r;
  assign slot_rank = rank_r;
  assign slot_data = data_r;
endmodule : cbs_slot_ctrl
`default_nettype wire

//--- cbs_pkg.sv
// Package of constants for the CAN message slot control word.
// Assumes one 16-bit control word per message slot, reached over AXI4-Lite.
package cbs_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_SLOT_CONTROL = 8'h00; // Control word of the slot
  localparam logic [7:0] OFS_SLOT_DATA = 8'h04; // Guarded payload word
  localparam logic [7:0] OFS_ENGINE_VIEW = 8'h08; // Engine side status, read only
  // Field positions in the control word
  localparam int LEN_MSB = 15; // Length code top bit
  localparam int LEN_LSB = 12; // Length code low bit
  localparam int RANK_MSB = 7; // Send rank code top bit
  localparam int RANK_LSB = 4; // Send rank code low bit
  localparam int COND_MSB = 3; // Condition top bit
  localparam int BUSY_BIT = 0; // Occupied flag position
  localparam logic [15:0] CONTROL_RESET = 16'h0000; // Reset value of control word
  localparam logic [31:0] DATA_RESET = 32'h00000000; // Reset value of payload word
  localparam logic [3:0] MAX_BYTES = 4'h8; // Largest payload in bytes
  // Condition codes
  localparam logic [3:0] C_RX_IDLE = 4'h0; // Receive idle
  localparam logic [3:0] C_RX_IDLE_BUSY = 4'h1; // Idle written during copy
  localparam logic [3:0] C_RX_ARMED = 4'h2; // Waiting for a frame
  localparam logic [3:0] C_RECV_COPY_FIRST = 4'h3; // First copy in progress
  localparam logic [3:0] C_RX_LOADED = 4'h4; // One frame held
  localparam logic [3:0] C_RECV_COPY_SECOND = 4'h5; // Second copy in progress
  localparam logic [3:0] C_RX_OVERWRITTEN = 4'h6; // Frame lost
  localparam logic [3:0] C_RECV_COPY_LATER = 4'h7; // Third or later copy
  localparam logic [3:0] C_TX_IDLE = 4'h8; // Send idle
  localparam logic [3:0] C_TX_IDLE_BUSY = 4'h9; // Idle written while queued
  localparam logic [3:0] C_AUTO_REMOTE_REPLY = 4'ha; // Automatic reply
  localparam logic [3:0] C_TX_RESERVED = 4'hb; // Never produced
  localparam logic [3:0] C_SEND_SINGLE = 4'hc; // Send once
  localparam logic [3:0] C_SEND_PENDING_PLAIN = 4'hd; // Queued or sending
  localparam logic [3:0] C_SEND_SINGLE_THEN_REPLY = 4'he; // Send then reply
  localparam logic [3:0] C_SEND_PENDING_REPLY = 4'hf; // Queued or sending, reply after
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00; // Accepted
  localparam logic [1:0] RESP_SLVERR = 2'b10; // Refused write, occupied slot
  localparam logic [1:0] RESP_DECERR = 2'b11; // Unmapped address
endpackage : cbs_pkg

//--- cbs_len_clamp.sv
// Clamp of a length code to the largest payload byte count.
// Assumes a four-bit plain binary length code.
`timescale 1ns/100ps
`default_nettype none
module cbs_len_clamp (
  input wire logic [3:0] len_code, // Raw length code
  output logic [3:0] byte_count // Bytes really moved, 0 to 8
);
  // Codes of eight and above all mean eight bytes
  assign byte_count = (len_code >= cbs_pkg::MAX_BYTES) ? cbs_pkg::MAX_BYTES : len_code;
endmodule : cbs_len_clamp
`default_nettype wire

//--- cbs_cond_next.sv
// Next condition code for one engine event, pure combinational.
// Several engine events in one cycle are ranked here: copy start, copy done, queue, then sent or abort.
`timescale 1ns/100ps
`default_nettype none
module cbs_cond_next (
  input wire logic [3:0] cond, // Present condition
  input wire logic copy_start, // Copy from hidden buffer begins
  input wire logic copy_done, // Copy finished
  input wire logic tx_queue, // Scheduler takes the slot
  input wire logic tx_done, // Frame sent
  input wire logic tx_abort, // Scheduler drops the slot
  output logic [3:0] cond_nxt, // Condition after the event
  output logic hit // Event changes the condition
);
  logic [3:0] after_copy; // Resting code after a copy
  logic [3:0] after_tx; // Resting code after sending
  // Copy end gives loaded after a first copy, idle after busy idle, overwritten otherwise
  assign after_copy = (cond == cbs_pkg::C_RECV_COPY_FIRST) ? cbs_pkg::C_RX_LOADED :
                      (cond == cbs_pkg::C_RX_IDLE_BUSY) ? cbs_pkg::C_RX_IDLE :
                      cbs_pkg::C_RX_OVERWRITTEN;
  // Send then reply falls back to automatic reply, others to idle
  assign after_tx = (cond == cbs_pkg::C_SEND_PENDING_REPLY) ? cbs_pkg::C_AUTO_REMOTE_REPLY :
                    (cond == cbs_pkg::C_SEND_PENDING_PLAIN) ? cbs_pkg::C_TX_IDLE :
                    cbs_pkg::C_TX_IDLE;
  always_comb
  begin
    cond_nxt = cond;
    hit = 1'b0;
    if (copy_start && !cond[cbs_pkg::COND_MSB] && cond != cbs_pkg::C_RX_IDLE && !cond[0])
    begin
      // Armed to 0011, loaded to 0101, overwritten to 0111
      cond_nxt = {cond[3:1], 1'b1};
      hit = 1'b1;
    end
    else if (copy_done && !cond[cbs_pkg::COND_MSB] && cond[0])
    begin
      cond_nxt = after_copy;
      hit = 1'b1;
    end
    else if (tx_queue && (cond == cbs_pkg::C_SEND_SINGLE ||
             cond == cbs_pkg::C_SEND_SINGLE_THEN_REPLY || cond == cbs_pkg::C_AUTO_REMOTE_REPLY))
    begin
      // Reply queued shows 1111, single shows 1101 or 1111
      cond_nxt = (cond == cbs_pkg::C_SEND_SINGLE) ? cbs_pkg::C_SEND_PENDING_PLAIN :
                 cbs_pkg::C_SEND_PENDING_REPLY;
      hit = 1'b1;
    end
    else if ((tx_done || tx_abort) && cond[cbs_pkg::COND_MSB] && cond[0])
    begin
      // An automatic reply that was sent stays armed as a reply
      cond_nxt = tx_abort ? {cond[3:1], 1'b0} : after_tx;
      hit = 1'b1;
    end
  end
endmodule : cbs_cond_next
`default_nettype wire

//--- cbs_slot_ctrl_properties.sv
// Checker of the slot control word, watching top-level ports only.
// Assumes it is bound to cbs_slot_ctrl from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module cbs_slot_chk (
  input wire logic ref_clk, // Module clock
  input wire logic rst, // Synchronous reset
  input wire logic eng_copy_start, // Copy begins
  input wire logic eng_copy_done, // Copy ends
  input wire logic [3:0] eng_rx_len, // Received length
  input wire logic eng_tx_queue, // Slot queued
  input wire logic eng_tx_done, // Frame sent
  input wire logic s_axi_rvalid, // Read answer valid
  input wire logic s_axi_rready, // Read answer taken
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_bvalid, // Write answer valid
  input wire logic s_axi_bready, // Write answer taken
  input wire logic [3:0] slot_condition, // Condition code
  input wire logic [3:0] slot_byte_count // Clamped byte count
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Lower priority events are only judged when no higher priority event comes with them
  wire logic hi_ev = eng_copy_start || eng_copy_done;
  wire logic only_done = eng_copy_done && !eng_copy_start;
  wire logic only_queue = eng_tx_queue && !hi_ev;
  wire logic only_sent = eng_tx_done && !eng_tx_queue && !hi_ev;
  after_reset_a: assert property ($fell(rst) |-> slot_condition == 4'h0 && !s_axi_bvalid)
    else $error("state not cleared by reset");
  first_copy_a: assert property (eng_copy_start && slot_condition == 4'h2 |=>
    slot_condition == 4'h3)
    else $error("armed slot did not show first copy");
  later_copy_a: assert property (eng_copy_start && slot_condition inside {4'h4, 4'h6} |=>
    slot_condition == $past(slot_condition) + 4'h1)
    else $error("repeated copy code wrong");
  copy_end_a: assert property (only_done && slot_condition == 4'h3 |=> slot_condition == 4'h4)
    else $error("finished copy did not load slot");
  len_clamp_a: assert property (only_done && slot_condition[0] && !slot_condition[3] |=>
    slot_byte_count == (($past(eng_rx_len) > 4'h8) ? 4'h8 : $past(eng_rx_len)))
    else $error("stored byte count wrong");
  queue_busy_a: assert property (only_queue && slot_condition == 4'hc |=> slot_condition == 4'hd)
    else $error("queued slot not busy");
  reply_after_a: assert property (only_sent && slot_condition == 4'hf |=> slot_condition == 4'ha)
    else $error("send then reply did not become reply");
  no_reserved_a: assert property (slot_condition != 4'hb)
    else $error("reserved condition produced");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  cover property (eng_copy_start && slot_condition == 4'h6);
  cover property (only_sent && slot_condition == 4'hf);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : cbs_slot_chk
`default_nettype wire

//--- cbs_eng_model.sv
// Behavioural protocol engine issuing one-cycle event pulses.
// Assumes the bench raises ev_go for one cycle per event.
`timescale 1ns/100ps
`default_nettype none
module cbs_eng_model (
  input wire logic ref_clk, // Module clock
  input wire logic rst, // Synchronous reset
  input wire logic ev_go, // One event asked for
  input wire logic [2:0] ev_code, // 0 start 1 done 2 queue 3 sent 4 abort
  input wire logic [3:0] ev_len, // Length for a finished copy
  input wire logic [31:0] ev_data, // Payload for a finished copy
  output var logic [4:0] ev_pulse, // One pulse line per event
  output var logic [3:0] rx_len, // Length beside done
  output var logic [31:0] rx_data // Payload beside done
);
  wire logic ev_done = ev_go && ev_code == 3'h1; // Copy finishing now
  // Pulses last one cycle; side lines toggle when not qualified,
  // so a design that samples them late sees garbage
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ev_pulse <= 5'h00;
      rx_len <= 4'h5;
      rx_data <= 32'ha5a5a5a5;
    end
    else
    begin
      ev_pulse <= ev_go ? (5'h01 << ev_code) : 5'h00;
      rx_len <= ev_done ? ev_len : ~rx_len;
      rx_data <= ev_done ? ev_data : ~rx_data;
    end
  end
endmodule : cbs_eng_model
`default_nettype wire

//--- cbs_slot_ctrl_tb_top.sv
// Self-checking bench for the slot control word over AXI4-Lite.
// Assumes the engine model file and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module cbs_slot_ctrl_tb_top;
  localparam logic [7:0] CTL = cbs_pkg::OFS_SLOT_CONTROL; // Control word
  localparam logic [7:0] DAT = cbs_pkg::OFS_SLOT_DATA; // Payload word
  localparam logic [1:0] OK = cbs_pkg::RESP_OKAY; // Accepted
  localparam logic [1:0] SLV = cbs_pkg::RESP_SLVERR; // Refused
  localparam logic [1:0] DEC = cbs_pkg::RESP_DECERR; // Unmapped
  logic ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ev_go;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, slot_data, eng_rx_data, ev_data;
  logic [3:0] s_axi_wstrb, slot_condition, slot_rank, slot_byte_count, eng_rx_len, ev_len;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] ev_pulse;
  logic [2:0] ev_code;
  int bad_count = 0;
  int check_count = 0;
  cbs_slot_ctrl DUT (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eng_copy_start(ev_pulse[0]),
    .eng_copy_done(ev_pulse[1]), .eng_rx_len, .eng_rx_data, .eng_tx_queue(ev_pulse[2]),
    .eng_tx_done(ev_pulse[3]), .eng_tx_abort(ev_pulse[4]), .slot_condition, .slot_rank,
    .slot_byte_count, .slot_data);
  cbs_eng_model u_eng (.ref_clk, .rst, .ev_go, .ev_code, .ev_len, .ev_data, .ev_pulse,
    .rx_len(eng_rx_len), .rx_data(eng_rx_data));
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // One write; every handshake is judged at the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic bv;
    logic [1:0] resp;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      bv = s_axi_bvalid;
      resp = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!bv);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask : wr
  // One read; data is taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic rv;
    logic [1:0] resp;
    logic [31:0] data;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      rv = s_axi_rvalid;
      resp = s_axi_rresp;
      data = s_axi_rdata;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!rv);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, resp});
    if (er == OK)
      chk("rdata", e, data);
  endtask : rd
  // One engine event, then the control word is read back
  task automatic eng(input logic [2:0] c, input logic [3:0] l, input logic [31:0] e);
    @(posedge ref_clk);
    ev_code <= c;
    ev_len <= l;
    ev_data <= {28'h5a5a5a5, l};
    ev_go <= 1'b1;
    @(posedge ref_clk);
    ev_go <= 1'b0;
    @(posedge ref_clk);
    rd(CTL, e, OK);
  endtask : eng
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Free-running module clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard, far beyond the roughly 150 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h3f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {ev_go, ev_code, ev_len, ev_data} = 40'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTL, 32'h0, OK);
    rd(DAT, 32'h0, OK);
    rd(8'h10, 32'h0, DEC);
    wr(8'h10, 32'h1, 4'hf, DEC);
    $display("test done: reset and map");
    wr(CTL, 32'h32, 4'h1, OK);
    eng(3'h0, 4'h0, 32'h33);
    wr(DAT, 32'h1234, 4'hf, SLV);
    wr(CTL, 32'h5000, 4'h2, SLV);
    eng(3'h1, 4'h9, 32'h8034);
    chk("byte count", 32'h8, {28'h0, slot_byte_count});
    rd(DAT, 32'h5a5a5a59, OK);
    eng(3'h0, 4'h0, 32'h8035);
    eng(3'h1, 4'h3, 32'h3036);
    eng(3'h0, 4'h0, 32'h3037);
    wr(CTL, 32'h30, 4'h1, OK);
    rd(CTL, 32'h3031, OK);
    eng(3'h1, 4'h5, 32'h5030);
    $display("test done: receive");
    wr(CTL, 32'h4b, 4'h1, OK);
    rd(CTL, 32'h5040, OK);
    wr(CTL, 32'hffff7f4c, 4'h3, OK);
    rd(CTL, 32'h704c, OK);
    chk("byte count", 32'h7, {28'h0, slot_byte_count});
    eng(3'h2, 4'h0, 32'h704d);
    eng(3'h4, 4'h0, 32'h704c);
    eng(3'h2, 4'h0, 32'h704d);
    eng(3'h3, 4'h0, 32'h7048);
    wr(CTL, 32'h4e, 4'h1, OK);
    eng(3'h2, 4'h0, 32'h704f);
    eng(3'h3, 4'h0, 32'h704a);
    eng(3'h2, 4'h0, 32'h704f);
    wr(CTL, 32'h48, 4'h1, OK);
    rd(CTL, 32'h7049, OK);
    eng(3'h3, 4'h0, 32'h7048);
    wr(CTL, 32'hc000, 4'h2, OK);
    rd(CTL, 32'hc048, OK);
    chk("byte count", 32'h8, {28'h0, slot_byte_count});
    $display("test done: transmit");
    give_verdict();
  end
endmodule : cbs_slot_ctrl_tb_top
// Checker sees only the top-level ports of the design
bind cbs_slot_ctrl cbs_slot_chk u_chk (.ref_clk, .rst, .eng_copy_start, .eng_copy_done,
  .eng_rx_len, .eng_tx_queue, .eng_tx_done, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .slot_condition, .slot_byte_count);
`default_nettype wire
